// ===== vgs_ext_grid_model.sv
// behavioural extension grid driver on the far side of the serial link
// assumes shift on the rising shift clock, latch transparent while enabled
module vgs_ext_grid_model (
  input  wire logic   shift_clk,
  input  wire logic   serial_in,
  input  wire logic   latch_en,
  input  wire logic   clear_n,
  output logic [15:0] grid_out
);
  logic [15:0] shift_q = 16'h0000;
  logic [15:0] latch_q = 16'h0000;

  always @(posedge shift_clk) begin
    shift_q <= {shift_q[14:0], serial_in};
  end

  always @(latch_en, shift_q) begin
    if (latch_en) begin
      latch_q = shift_q;
    end
  end

  assign grid_out = clear_n ? latch_q : 16'h0000;
endmodule : vgs_ext_grid_model

// ===== vgs_grid_scan.sv
// grid scan, strap configuration and extension grid driver link of a dot-matrix
// fluorescent display controller, with an AHB-Lite register slave
// assumes straps and oscillator arrive asynchronously; bus signals are on SYS_CLK

module vgs_grid_scan (
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic             HREADYOUT,
  output logic [31:0]      HRDATA,
  output logic [1:0]       HRESP,
  input  wire logic        OSC_IN,
  input  wire logic        BUS_KIND_STRAP,
  input  wire logic        BUS_STYLE_STRAP,
  input  wire logic        LINE_COUNT_STRAP,
  input  wire logic        TEST_PIN,
  input  wire logic        DUTY_SEL_LO,
  input  wire logic        DUTY_SEL_HI,
  input  wire logic        ANODE_ORDER_SEL_A,
  input  wire logic        ANODE_ORDER_SEL_B,
  output logic             OSC_CLOCK_OUT,
  output logic [23:0]      GRID_OUTPUTS,
  output logic [79:0]      ANODE_OUTPUTS,
  output logic             EXT_GRID_SERIAL_OUT,
  output logic             EXT_GRID_SHIFT_CLK,
  output logic             EXT_GRID_CLEAR_N,
  output logic             EXT_GRID_LATCH_EN,
  output logic             HOST_SERIAL_MODE,
  output logic             HOST_ENABLE_STROBE,
  output logic             HOST_WORD8,
  output logic             TWO_LINE,
  output logic             TEST_MODE
);

  localparam int NSTRAP = 9;

  logic [NSTRAP-1:0]           strap_s1_q;
  logic [NSTRAP-1:0]           strap_s2_q;
  logic                        osc_s1_q;
  logic                        osc_s2_q;
  logic                        osc_s3_q;
  logic [1:0]                  cap_cnt_q;
  logic                        strap_done_q;
  logic                        bus_kind_q;
  logic                        bus_style_q;
  logic                        line_strap_q;
  vgs_pkg::vgs_duty_type       duty_q;
  logic [1:0]                  order_q;
  logic [vgs_pkg::CTRL_WIDTH-1:0] ctrl_q;
  logic [vgs_pkg::NUM_COLS-1:0] cols_q;
  logic                        wr_pend_q;
  logic [7:0]                  wr_addr_q;
  logic [5:0]                  grid_idx_q;
  logic [5:0]                  grid_idx_d;
  logic [5:0]                  grid_cnt;
  logic                        scan_on;
  logic                        osc_rise;
  logic                        slot_tick;
  logic                        addr_take;
  logic                        page_hit;
  logic [31:0]                 rd_mux;
  logic [31:0]                 status_word;
  logic [vgs_pkg::NUM_COLS-1:0] anode_map;
  logic [vgs_pkg::EXT_GRIDS-1:0] ext_pat;
  vgs_pkg::vgs_ext_state_type  ext_state_q;
  logic [3:0]                  half_cnt_q;
  logic [3:0]                  bit_cnt_q;
  logic [vgs_pkg::EXT_GRIDS-1:0] ext_sh_q;
  logic                        is40;

  // pins from outside the clock domain pass two flops first
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      strap_s1_q <= '0;
      strap_s2_q <= '0;
      osc_s1_q   <= 1'b0;
      osc_s2_q   <= 1'b0;
      osc_s3_q   <= 1'b0;
    end else begin
      strap_s1_q <= {ANODE_ORDER_SEL_B, ANODE_ORDER_SEL_A, DUTY_SEL_HI, DUTY_SEL_LO,
                     TEST_PIN, LINE_COUNT_STRAP, BUS_STYLE_STRAP, BUS_KIND_STRAP,
                     1'b0};
      strap_s2_q <= strap_s1_q;
      osc_s1_q   <= OSC_IN;
      osc_s2_q   <= osc_s1_q;
      osc_s3_q   <= osc_s2_q;
    end
  end

  assign osc_rise = osc_s2_q & ~osc_s3_q;

  // straps other than the test pin are caught once, after the synchronisers have filled
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cap_cnt_q    <= '0;
      strap_done_q <= 1'b0;
      bus_kind_q   <= 1'b0;
      bus_style_q  <= 1'b0;
      line_strap_q <= 1'b0;
      duty_q       <= vgs_pkg::DUTY_16;
      order_q      <= '0;
    end else if (!strap_done_q) begin
      cap_cnt_q <= cap_cnt_q + 2'h1;
      if (cap_cnt_q == vgs_pkg::STRAP_CAPTURE) begin
        strap_done_q <= 1'b1;
        bus_kind_q   <= strap_s2_q[1];
        bus_style_q  <= strap_s2_q[2];
        line_strap_q <= strap_s2_q[3];
        duty_q       <= vgs_pkg::vgs_duty_type'({strap_s2_q[5], strap_s2_q[6]});
        order_q      <= {strap_s2_q[7], strap_s2_q[8]};
      end
    end
  end

  // AHB-Lite slave: zero wait states, read data fetched in the address phase
  assign addr_take = HSEL & HREADY & HTRANS[vgs_pkg::HTRANS_ACTIVE];
  assign page_hit  = (HADDR[31:8] == vgs_pkg::REG_PAGE);

  always_comb begin
    status_word = '0;
    status_word[vgs_pkg::ST_BUS_KIND]  = bus_kind_q;
    status_word[vgs_pkg::ST_BUS_STYLE] = bus_style_q;
    status_word[vgs_pkg::ST_TEST]      = strap_s2_q[4];
    status_word[vgs_pkg::ST_LINE]      = line_strap_q;
    status_word[vgs_pkg::ST_DUTY_LSB +: 2]  = duty_q;
    status_word[vgs_pkg::ST_ORDER_LSB +: 2] = order_q;
    status_word[vgs_pkg::ST_GRID_LSB +: 6]  = grid_idx_q;
    status_word[vgs_pkg::ST_DONE]      = strap_done_q;
  end

  always_comb begin
    rd_mux = '0;
    if (page_hit) begin
      case (HADDR[7:0])
        vgs_pkg::REG_CTRL:   rd_mux = {29'h0, ctrl_q};
        vgs_pkg::REG_STATUS: rd_mux = status_word;
        vgs_pkg::REG_COL0:   rd_mux = cols_q[31:0];
        vgs_pkg::REG_COL1:   rd_mux = cols_q[63:32];
        vgs_pkg::REG_COL2:   rd_mux = {16'h0, cols_q[79:64]};
        default:             rd_mux = '0;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      HRDATA    <= '0;
      HREADYOUT <= 1'b1;
      HRESP     <= vgs_pkg::HRESP_OKAY;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= vgs_pkg::HRESP_OKAY;
      wr_pend_q <= addr_take & HWRITE & page_hit;
      wr_addr_q <= HADDR[7:0];
      if (addr_take && !HWRITE) begin
        HRDATA <= rd_mux;
      end
    end
  end

  // two-line flag reloads from its strap after every reset
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_q <= vgs_pkg::CTRL_RESET;
      cols_q <= '0;
    end else begin
      if (!strap_done_q && cap_cnt_q == vgs_pkg::STRAP_CAPTURE) begin
        ctrl_q[vgs_pkg::CTRL_TWO_LINE] <= strap_s2_q[3];
      end else if (wr_pend_q && wr_addr_q == vgs_pkg::REG_CTRL) begin
        ctrl_q <= HWDATA[vgs_pkg::CTRL_WIDTH-1:0];
      end
      if (wr_pend_q) begin
        case (wr_addr_q)
          vgs_pkg::REG_COL0: cols_q[31:0]  <= HWDATA;
          vgs_pkg::REG_COL1: cols_q[63:32] <= HWDATA;
          vgs_pkg::REG_COL2: cols_q[79:64] <= HWDATA[vgs_pkg::COL2_BITS-1:0];
          default:           cols_q        <= cols_q;
        endcase
      end
    end
  end

  // host mode levels for the host interface logic
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      HOST_SERIAL_MODE   <= 1'b0;
      HOST_ENABLE_STROBE <= 1'b0;
      HOST_WORD8         <= 1'b0;
      TWO_LINE           <= 1'b0;
      TEST_MODE          <= 1'b0;
      OSC_CLOCK_OUT      <= 1'b0;
    end else begin
      HOST_SERIAL_MODE   <= strap_done_q & ~bus_kind_q;
      HOST_ENABLE_STROBE <= strap_done_q & bus_style_q;
      // serial words are always whole bytes; parallel width comes from the instruction
      HOST_WORD8         <= ~bus_kind_q | ctrl_q[vgs_pkg::CTRL_WORD8];
      TWO_LINE           <= ctrl_q[vgs_pkg::CTRL_TWO_LINE];
      TEST_MODE          <= strap_s2_q[4];
      OSC_CLOCK_OUT      <= osc_s2_q;
    end
  end

  // grid scan
  assign scan_on  = strap_done_q & ctrl_q[vgs_pkg::CTRL_SCAN_EN];
  assign grid_cnt = vgs_pkg::grid_count(duty_q);
  assign is40     = (duty_q == vgs_pkg::DUTY_40);

  vgs_slot_timer #(
    .WIDTH (8)
  ) u_slot (
    .clk   (SYS_CLK),
    .rst_n (RESET_N),
    .run   (scan_on),
    .step  (osc_rise),
    .limit (vgs_pkg::SLOT_OSC_EDGES),
    .tick  (slot_tick)
  );

  always_comb begin
    if (grid_idx_q >= grid_cnt - 6'h1) begin
      grid_idx_d = '0;
    end else begin
      grid_idx_d = grid_idx_q + 6'h1;
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      grid_idx_q <= '0;
    end else if (!scan_on) begin
      grid_idx_q <= '0;
    end else if (slot_tick) begin
      grid_idx_q <= grid_idx_d;
    end
  end

  // anode order: both low ascending, mixed first forty reversed, both high low forty from the upper columns, upper forty from the lower ones reversed
  always_comb begin
    anode_map = '0;
    for (int k = 0; k < vgs_pkg::NUM_COLS; k++) begin
      case (order_q)
        2'h0: anode_map[k] = cols_q[k];
        2'h3: anode_map[k] = (k < vgs_pkg::HALF_COLS) ? cols_q[k + vgs_pkg::HALF_COLS]
                                                     : cols_q[vgs_pkg::NUM_COLS - 1 - k];
        default: anode_map[k] = (k < vgs_pkg::HALF_COLS) ? cols_q[vgs_pkg::HALF_COLS - 1 - k]
                                                        : cols_q[k];
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      GRID_OUTPUTS  <= '0;
      ANODE_OUTPUTS <= '0;
    end else begin
      for (int g = 0; g < vgs_pkg::NUM_GRID_PINS; g++) begin
        GRID_OUTPUTS[g] <= scan_on && (grid_idx_q == 6'(g));
      end
      ANODE_OUTPUTS <= scan_on ? anode_map : '0;
    end
  end

  // one-hot extension pattern for the grid that follows the current one
  always_comb begin
    ext_pat = '0;
    for (int j = 0; j < vgs_pkg::EXT_GRIDS; j++) begin
      ext_pat[j] = (grid_idx_d == vgs_pkg::EXT_BASE + 6'(j));
    end
  end

  // the pattern for the next slot is shifted during this slot and latched at its tick,
  // so a whole slot hides the shifting; the latch only needs the slot to outlast 16 bits
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ext_state_q         <= vgs_pkg::EXT_IDLE;
      half_cnt_q          <= '0;
      bit_cnt_q           <= '0;
      ext_sh_q            <= '0;
      EXT_GRID_SERIAL_OUT <= 1'b0;
      EXT_GRID_SHIFT_CLK  <= 1'b0;
      EXT_GRID_LATCH_EN   <= 1'b0;
      EXT_GRID_CLEAR_N    <= 1'b0;
    end else if (!scan_on || !is40) begin
      ext_state_q         <= vgs_pkg::EXT_IDLE;
      half_cnt_q          <= '0;
      bit_cnt_q           <= '0;
      EXT_GRID_SERIAL_OUT <= 1'b0;
      EXT_GRID_SHIFT_CLK  <= 1'b0;
      EXT_GRID_LATCH_EN   <= 1'b0;
      EXT_GRID_CLEAR_N    <= 1'b0;
    end else if (slot_tick) begin
      ext_state_q        <= vgs_pkg::EXT_LATCH;
      half_cnt_q         <= '0;
      EXT_GRID_SHIFT_CLK <= 1'b0;
      EXT_GRID_LATCH_EN  <= 1'b1;
      EXT_GRID_CLEAR_N   <= (grid_idx_d >= vgs_pkg::EXT_BASE);
    end else begin
      half_cnt_q <= half_cnt_q + 4'h1;
      case (ext_state_q)
        vgs_pkg::EXT_LATCH: begin
          if (half_cnt_q == vgs_pkg::EXT_HALF_CYC - 4'h1) begin
            EXT_GRID_LATCH_EN   <= 1'b0;
            ext_sh_q            <= ext_pat;
            EXT_GRID_SERIAL_OUT <= ext_pat[vgs_pkg::EXT_GRIDS-1];
            bit_cnt_q           <= '0;
            half_cnt_q          <= '0;
            ext_state_q         <= vgs_pkg::EXT_CLK_LO;
          end
        end
        vgs_pkg::EXT_CLK_LO: begin
          if (half_cnt_q == vgs_pkg::EXT_HALF_CYC - 4'h1) begin
            EXT_GRID_SHIFT_CLK <= 1'b1;
            half_cnt_q         <= '0;
            ext_state_q        <= vgs_pkg::EXT_CLK_HI;
          end
        end
        vgs_pkg::EXT_CLK_HI: begin
          if (half_cnt_q == vgs_pkg::EXT_HALF_CYC - 4'h1) begin
            EXT_GRID_SHIFT_CLK  <= 1'b0;
            half_cnt_q          <= '0;
            bit_cnt_q           <= bit_cnt_q + 4'h1;
            ext_sh_q            <= {ext_sh_q[vgs_pkg::EXT_GRIDS-2:0], 1'b0};
            EXT_GRID_SERIAL_OUT <= ext_sh_q[vgs_pkg::EXT_GRIDS-2];
            if (bit_cnt_q == vgs_pkg::EXT_LAST_BIT) begin
              EXT_GRID_SERIAL_OUT <= 1'b0;
              ext_state_q         <= vgs_pkg::EXT_IDLE;
            end else begin
              ext_state_q         <= vgs_pkg::EXT_CLK_LO;
            end
          end
        end
        default: begin
          half_cnt_q  <= '0;
          ext_state_q <= vgs_pkg::EXT_IDLE;
        end
      endcase
    end
  end

endmodule : vgs_grid_scan

// ===== vgs_grid_scan_assertions.sv
// checker on the grid scan block ports: reset, scan, extension link, host mode
// assumes one clock domain and an asynchronous active-low reset
module vgs_grid_scan_chk (
  input wire logic        SYS_CLK,
  input wire logic        RESET_N,
  input wire logic        OSC_IN,
  input wire logic        TEST_PIN,
  input wire logic        OSC_CLOCK_OUT,
  input wire logic [23:0] GRID_OUTPUTS,
  input wire logic [79:0] ANODE_OUTPUTS,
  input wire logic        EXT_GRID_SERIAL_OUT,
  input wire logic        EXT_GRID_SHIFT_CLK,
  input wire logic        EXT_GRID_CLEAR_N,
  input wire logic        EXT_GRID_LATCH_EN,
  input wire logic        HOST_SERIAL_MODE,
  input wire logic        HOST_WORD8,
  input wire logic        TEST_MODE
);
  default clocking cb @(posedge SYS_CLK);
  endclocking

  // no disable: the outputs must stay dark while reset is held
  property p_dark;
    !RESET_N |-> GRID_OUTPUTS == 24'h000000 && ANODE_OUTPUTS == 80'h0;
  endproperty
  a_dark: assert property (p_dark) else $error("outputs lit in reset");

  property p_one_grid;
    disable iff (!RESET_N) $onehot0(GRID_OUTPUTS);
  endproperty
  a_one_grid: assert property (p_one_grid) else $error("two grids active");

  property p_serial_word;
    disable iff (!RESET_N) HOST_SERIAL_MODE |-> HOST_WORD8;
  endproperty
  a_serial_word: assert property (p_serial_word) else $error("serial word not 8 bit");

  // one cycle overlap allowed: the clear moves at the tick, grids a cycle later
  property p_ext_slot;
    disable iff (!RESET_N) EXT_GRID_CLEAR_N && $past(EXT_GRID_CLEAR_N) |->
      GRID_OUTPUTS == 24'h000000;
  endproperty
  a_ext_slot: assert property (p_ext_slot) else $error("internal grid in ext slot");

  property p_latch_pulse;
    disable iff (!RESET_N) $rose(EXT_GRID_LATCH_EN) |=>
      EXT_GRID_LATCH_EN ##1 !EXT_GRID_LATCH_EN;
  endproperty
  a_latch_pulse: assert property (p_latch_pulse) else $error("latch pulse length");

  property p_data_setup;
    disable iff (!RESET_N) $rose(EXT_GRID_SHIFT_CLK) |-> $stable(EXT_GRID_SERIAL_OUT);
  endproperty
  a_data_setup: assert property (p_data_setup) else $error("data moves at shift");

  property p_no_shift_latch;
    disable iff (!RESET_N) EXT_GRID_LATCH_EN |-> !EXT_GRID_SHIFT_CLK;
  endproperty
  a_no_shift_latch: assert property (p_no_shift_latch) else $error("shift in latch");

  property p_osc_out;
    disable iff (!RESET_N) $past(RESET_N, 3) |-> OSC_CLOCK_OUT == $past(OSC_IN, 3);
  endproperty
  a_osc_out: assert property (p_osc_out) else $error("clock out not following");

  property p_test;
    disable iff (!RESET_N) $stable(TEST_PIN)[*6] |-> TEST_MODE == TEST_PIN;
  endproperty
  a_test: assert property (p_test) else $error("test mode not following");

  c_ext: cover property (disable iff (!RESET_N) $rose(EXT_GRID_CLEAR_N));
  c_test: cover property (disable iff (!RESET_N) $rose(TEST_MODE));
  c_frame: cover property (disable iff (!RESET_N) $rose(GRID_OUTPUTS[0]));
endmodule : vgs_grid_scan_chk

bind vgs_grid_scan vgs_grid_scan_chk u_chk (
  .SYS_CLK(SYS_CLK), .RESET_N(RESET_N), .OSC_IN(OSC_IN), .TEST_PIN(TEST_PIN),
  .OSC_CLOCK_OUT(OSC_CLOCK_OUT), .GRID_OUTPUTS(GRID_OUTPUTS),
  .ANODE_OUTPUTS(ANODE_OUTPUTS), .EXT_GRID_SERIAL_OUT(EXT_GRID_SERIAL_OUT),
  .EXT_GRID_SHIFT_CLK(EXT_GRID_SHIFT_CLK), .EXT_GRID_CLEAR_N(EXT_GRID_CLEAR_N),
  .EXT_GRID_LATCH_EN(EXT_GRID_LATCH_EN), .HOST_SERIAL_MODE(HOST_SERIAL_MODE),
  .HOST_WORD8(HOST_WORD8), .TEST_MODE(TEST_MODE)
);

// ===== vgs_grid_scan_tb.sv
// self-checking bench for the grid scan block: strap sets, scan length, anode
// order and extension link; assumes a zero-wait slave on its own hready
module vgs_grid_scan_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic        sys_clk, reset_n, hsel, hwrite, osc_in, hready;
  logic        ext_grid_serial_out, ext_grid_shift_clk, clr_n, le, ser_mode, en_strobe, word8, two_line, test_mode;
  logic [1:0]  htrans, osc_cnt, hresp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  cfg;
  logic [23:0] grid;
  logic [79:0] anode;
  logic [15:0] ext_out;
  int          cyc, error_cnt, checks_done;
  int          grids_exp [4] = '{16, 20, 24, 40};
  // strap sets: kind, style, line, test, duty lo, duty hi, order a, order b
  logic [7:0]  cfgs [4] = '{8'h00, 8'hF5, 8'h8A, 8'h6F};

  vgs_grid_scan DUT (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
    .HREADY(hready), .HREADYOUT(hready), .HRDATA(hrdata), .HRESP(hresp),
    .OSC_IN(osc_in), .BUS_KIND_STRAP(cfg[7]), .BUS_STYLE_STRAP(cfg[6]),
    .LINE_COUNT_STRAP(cfg[5]), .TEST_PIN(cfg[4]), .DUTY_SEL_LO(cfg[3]),
    .DUTY_SEL_HI(cfg[2]), .ANODE_ORDER_SEL_A(cfg[1]), .ANODE_ORDER_SEL_B(cfg[0]),
    .OSC_CLOCK_OUT(), .GRID_OUTPUTS(grid), .ANODE_OUTPUTS(anode),
    .EXT_GRID_SERIAL_OUT(ext_grid_serial_out), .EXT_GRID_SHIFT_CLK(ext_grid_shift_clk), .EXT_GRID_CLEAR_N(clr_n),
    .EXT_GRID_LATCH_EN(le), .HOST_SERIAL_MODE(ser_mode),
    .HOST_ENABLE_STROBE(en_strobe), .HOST_WORD8(word8), .TWO_LINE(two_line),
    .TEST_MODE(test_mode)
  );

  vgs_ext_grid_model u_ext (
    .shift_clk(ext_grid_shift_clk), .serial_in(ext_grid_serial_out), .latch_en(le), .clear_n(clr_n),
    .grid_out(ext_out)
  );

  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  // oscillator is 200 ns; the watchdog ceiling is about twice the expected run
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    osc_cnt <= osc_cnt + 2'h1;
    if (osc_cnt == 2'h3) begin
      osc_in <= ~osc_in;
    end
    if (cyc == 60000) begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic stop_test();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [79:0] exp, input logic [79:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic bus(input logic [31:0] a, input logic w, input logic [31:0] d,
                     output logic [31:0] r);
    @(posedge sys_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge sys_clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge sys_clk); while (hready !== 1'b1);
    r = hrdata;
  endtask : bus

  task automatic wait_grid0();
    while (grid[0] !== 1'b0) @(posedge sys_clk);
    while (grid[0] !== 1'b1) @(posedge sys_clk);
  endtask : wait_grid0

  task automatic run_cfg(input logic [7:0] c);
    logic [31:0] r;
    logic [79:0] cols, exp;
    int          n, k, m;
    reset_n <= 1'b0;
    cfg <= c;
    repeat (20) @(posedge sys_clk);
    check("grids in reset", 80'h0, grid);
    check("anodes in reset", 80'h0, anode);
    reset_n <= 1'b1;
    n = 0;
    r = 32'h0;
    while (r[14] !== 1'b1 && n < 20) begin
      bus(32'h04, 1'b0, 32'h0, r);
      n++;
    end
    check("straps captured", 1'b1, r[14]);
    check("status straps", {c[1:0], c[3:2], c[5], c[4], c[6], c[7]}, r[7:0]);
    check("serial mode", !c[7], ser_mode);
    check("enable strobe", c[6], en_strobe);
    check("two line", c[5], two_line);
    check("test mode", c[4], test_mode);
    bus(32'h00, 1'b0, 32'h0, r);
    check("ctrl reset", {c[5], 2'h1}, r[2:0]);
    bus(32'h00, 1'b1, {29'h0, c[5], 2'h3}, r);
    repeat (2) @(posedge sys_clk);
    check("word8 set", 1'b1, word8);
    bus(32'h00, 1'b1, {29'h0, c[5], 2'h1}, r);
    repeat (2) @(posedge sys_clk);
    check("word8 clear", !c[7], word8);
    bus(32'h14, 1'b0, 32'h0, r);
    check("unmapped read", 32'h0, r);
    check("bus response", 2'h0, hresp);
    bus(32'h08, 1'b1, 32'h00000001, r);
    bus(32'h0C, 1'b1, 32'h00002080, r);
    bus(32'h10, 1'b1, 32'h00008000, r);
    cols = {16'h8000, 32'h00002080, 32'h00000001};
    for (k = 0; k < 80; k++) begin
      m = k;
      if (c[1:0] == 2'h3) begin
        m = (k < 40) ? 40 + k : 79 - k;
      end else if (c[1] ^ c[0]) begin
        m = (k < 40) ? 39 - k : k;
      end
      exp[k] = cols[m];
    end
    repeat (4) @(posedge sys_clk);
    check("anode map", exp, anode);
    wait_grid0();
    n = cyc;
    wait_grid0();
    check("grids per frame", grids_exp[c[3:2]], (cyc - n + 64) / 128);
    if (c[3:2] == 2'h3) begin
      while (clr_n !== 1'b1) @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      check("ext grid 25", 16'h0001, ext_out);
      while (le !== 1'b1) @(posedge sys_clk);
      repeat (4) @(posedge sys_clk);
      check("ext grid 26", 16'h0002, ext_out);
      check("internal grids off", 24'h0, grid);
    end else begin
      check("ext cleared", 16'h0, ext_out);
    end
  endtask : run_cfg

  initial begin
    reset_n = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    osc_in = 1'b0;
    osc_cnt = 2'h0;
    cfg = 8'h00;
    cyc = 0;
    error_cnt = 0;
    checks_done = 0;
    @(posedge sys_clk);
    for (int i = 0; i < 4; i++) begin
      run_cfg(cfgs[i]);
    end
    stop_test();
  end
endmodule : vgs_grid_scan_tb

// ===== vgs_slot_timer.sv
// holds the shared constants package and the grid slot timer
// assumes one system clock, an async active-low reset and a one-cycle step strobe

package vgs_pkg;

  // register byte offsets
  localparam logic [7:0]  REG_CTRL         = 8'h00;
  localparam logic [7:0]  REG_STATUS       = 8'h04;
  localparam logic [7:0]  REG_COL0         = 8'h08;
  localparam logic [7:0]  REG_COL1         = 8'h0C;
  localparam logic [7:0]  REG_COL2         = 8'h10;
  localparam logic [23:0] REG_PAGE         = 24'h000000;

  // control fields
  localparam int          CTRL_SCAN_EN     = 0;
  localparam int          CTRL_WORD8       = 1;
  localparam int          CTRL_TWO_LINE    = 2;
  localparam int          CTRL_WIDTH       = 3;
  localparam logic [2:0]  CTRL_RESET       = 3'h1;

  // status fields
  localparam int          ST_BUS_KIND      = 0;
  localparam int          ST_BUS_STYLE     = 1;
  localparam int          ST_TEST          = 2;
  localparam int          ST_LINE          = 3;
  localparam int          ST_DUTY_LSB      = 4;
  localparam int          ST_ORDER_LSB     = 6;
  localparam int          ST_GRID_LSB      = 8;
  localparam int          ST_DONE          = 14;

  // geometry
  localparam int          NUM_COLS         = 80;
  localparam int          HALF_COLS        = 40;
  localparam int          NUM_GRID_PINS    = 24;
  localparam int          EXT_GRIDS        = 16;
  localparam int          COL2_BITS        = 16;
  localparam logic [5:0]  EXT_BASE         = 6'h18;
  localparam logic [5:0]  GRIDS_16         = 6'h10;
  localparam logic [5:0]  GRIDS_20         = 6'h14;
  localparam logic [5:0]  GRIDS_24         = 6'h18;
  localparam logic [5:0]  GRIDS_40         = 6'h28;

  // timing
  localparam int          SYS_CLK_MHZ      = 40;
  localparam int          EXT_HALF_NS      = 50;
  localparam int          EXT_HALF_CYC_I   = (EXT_HALF_NS * SYS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  EXT_HALF_CYC     = 4'(EXT_HALF_CYC_I < 1 ? 1 : EXT_HALF_CYC_I);
  localparam logic [3:0]  EXT_LAST_BIT     = 4'hF;
  localparam logic [7:0]  SLOT_OSC_EDGES   = 8'h10;
  localparam logic [1:0]  STRAP_CAPTURE    = 2'h3;

  localparam logic [1:0]  HRESP_OKAY       = 2'h0;
  localparam int          HTRANS_ACTIVE    = 1;

  typedef enum logic [1:0] {
    DUTY_16 = 2'h0,
    DUTY_20 = 2'h1,
    DUTY_24 = 2'h2,
    DUTY_40 = 2'h3
  } vgs_duty_type;

  typedef enum logic [1:0] {
    EXT_IDLE   = 2'h0,
    EXT_LATCH  = 2'h1,
    EXT_CLK_LO = 2'h3,
    EXT_CLK_HI = 2'h2
  } vgs_ext_state_type;

  function automatic logic [5:0] grid_count(input vgs_duty_type duty);
    case (duty)
      DUTY_16: grid_count = GRIDS_16;
      DUTY_20: grid_count = GRIDS_20;
      DUTY_24: grid_count = GRIDS_24;
      default: grid_count = GRIDS_40;
    endcase
  endfunction : grid_count

endpackage : vgs_pkg

module vgs_slot_timer #(
  parameter int         WIDTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic             step,
  input  wire logic [WIDTH-1:0] limit,
  output logic                  tick
);

  logic [WIDTH-1:0] count_q;

  // one tick after every limit steps; a stopped timer restarts from zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= '0;
      tick    <= 1'b0;
    end else if (!run) begin
      count_q <= '0;
      tick    <= 1'b0;
    end else if (step) begin
      if (count_q == limit - WIDTH'(1)) begin
        count_q <= '0;
        tick    <= 1'b1;
      end else begin
        count_q <= count_q + WIDTH'(1);
        tick    <= 1'b0;
      end
    end else begin
      tick    <= 1'b0;
    end
  end

endmodule : vgs_slot_timer
